// >>> gpop_board_model.sv
// board side of the gpio pins: resolves each wire from both drivers
module gpop_board_model (
    input wire logic [6:0] drv_oe,
    input wire logic [6:0] drv_lvl,
    input wire logic [6:0] ext_lvl,
    output logic [6:0] pin_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    // the board drives a pin only once the port has released it
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            pin_lvl[i] = drv_oe[i] ? drv_lvl[i] : ext_lvl[i];
        end
    end
endmodule : gpop_board_model

// >>> gpop_pin_if.sv
// carrier between the register side and the pin multiplexer
interface gpop_pin_if;
    import gpop_pkg::*;

    logic [6:0] dir;
    logic [6:0] data;
    gpop_panel_t panel;
    gpop_panel_sig_t sig;
    logic [6:0] pin_out;
    logic [6:0] pin_oe;
    logic [6:0] taken;

    modport ctrl (
        output dir,
        output data,
        output panel,
        output sig,
        input pin_out,
        input pin_oe,
        input taken
    );

    modport mux (
        input dir,
        input data,
        input panel,
        input sig,
        output pin_out,
        output pin_oe,
        output taken
    );
endinterface : gpop_pin_if

// >>> gpop_pin_mux.sv
// per-pin choice between software data and panel timing signals
module gpop_pin_mux (
    gpop_pin_if.mux pins
);
    import gpop_pkg::*;

    logic [6:0] auto_level;

    // panel signals placed on their pins per panel kind
    always_comb begin
        auto_level = GPOP_RST_PINS;
        unique case (pins.panel)
            GPOP_PANEL_FIRST: begin
                auto_level[0] = pins.sig.display_inhibit_signal;
                auto_level[1] = pins.sig.vertical_shift_clock;
                auto_level[2] = pins.sig.frame_polarity_signal;
                auto_level[3] = pins.sig.frame_reset_signal;
                auto_level[4] = pins.sig.panel_reset_signal;
                auto_level[5] = pins.sig.panel_drive_signal;
            end
            GPOP_PANEL_SECOND: begin
                auto_level[0] = pins.sig.panel_power_save_signal;
                auto_level[1] = pins.sig.clock_select_signal;
                auto_level[2] = pins.sig.panel_reversal_signal;
                auto_level[3] = pins.sig.start_pulse_signal;
            end
            GPOP_PANEL_PLAIN: begin
                auto_level = GPOP_RST_PINS;
            end
        endcase
    end

    assign pins.taken = gpop_taken_pins(pins.panel);

    // taken pins always drive; others obey their direction bit
    for (genvar i = 0; i < 7; i++) begin : g_pin
        assign pins.pin_out[i] = pins.taken[i] ? auto_level[i] : pins.data[i];
        assign pins.pin_oe[i] = pins.taken[i] | pins.dir[i];
    end
endmodule : gpop_pin_mux

// >>> gpop_pkg.sv
// constants, types and decode shared by the panel override gpio port
package gpop_pkg;

    // register bus geometry
    localparam int GPOP_ADDR_W = 8;
    localparam int GPOP_DATA_W = 8;
    localparam int GPOP_PIN_N = 7;

    // register offsets
    localparam logic [7:0] GPOP_OFS_PANEL_CFG = 8'h10;
    localparam logic [7:0] GPOP_OFS_PIN_DIR = 8'hA8;
    localparam logic [7:0] GPOP_OFS_INPUT_CFG = 8'hA9;
    localparam logic [7:0] GPOP_OFS_PIN_STATE = 8'hAC;
    localparam logic [7:0] GPOP_OFS_GEN_OUT = 8'hAD;

    // field positions
    localparam int GPOP_INPUT_EN_BIT = 7;
    localparam int GPOP_GEN_OUT_BIT = 7;
    localparam int GPOP_PANEL_LSB = 0;
    localparam int GPOP_PANEL_W = 2;

    // reset values
    localparam logic [7:0] GPOP_RST_BYTE = 8'h00;
    localparam logic [6:0] GPOP_RST_PINS = 7'h00;
    localparam logic [1:0] GPOP_RST_PANEL = 2'h0;

    // panel-type field codes
    localparam logic [1:0] GPOP_CODE_FIRST = 2'h3;
    localparam logic [1:0] GPOP_CODE_SECOND = 2'h2;

    // pins taken over by each special panel type
    localparam logic [6:0] GPOP_TAKE_FIRST = 7'h3F;
    localparam logic [6:0] GPOP_TAKE_SECOND = 7'h0F;

    typedef enum logic [1:0] {
        GPOP_PANEL_PLAIN,
        GPOP_PANEL_FIRST,
        GPOP_PANEL_SECOND
    } gpop_panel_t;

    // internally generated panel timing signals
    typedef struct packed {
        logic panel_drive_signal;
        logic panel_reset_signal;
        logic frame_reset_signal;
        logic start_pulse_signal;
        logic frame_polarity_signal;
        logic panel_reversal_signal;
        logic vertical_shift_clock;
        logic clock_select_signal;
        logic display_inhibit_signal;
        logic panel_power_save_signal;
    } gpop_panel_sig_t;

    // panel-type field to panel kind
    function automatic gpop_panel_t gpop_decode_panel(input logic [1:0] field);
        gpop_panel_t kind;
        kind = GPOP_PANEL_PLAIN;
        if (field == GPOP_CODE_FIRST) begin
            kind = GPOP_PANEL_FIRST;
        end else if (field == GPOP_CODE_SECOND) begin
            kind = GPOP_PANEL_SECOND;
        end
        return kind;
    endfunction : gpop_decode_panel

    // which pins a panel kind takes away from software
    function automatic logic [6:0] gpop_taken_pins(input gpop_panel_t kind);
        logic [6:0] mask;
        mask = GPOP_RST_PINS;
        if (kind == GPOP_PANEL_FIRST) begin
            mask = GPOP_TAKE_FIRST;
        end else if (kind == GPOP_PANEL_SECOND) begin
            mask = GPOP_TAKE_SECOND;
        end
        return mask;
    endfunction : gpop_taken_pins

endpackage : gpop_pkg

// >>> gpop_port.sv
// gpio port of an lcd controller whose pins may be taken over by panel timing
// register map, byte offsets on the host bus
// 10h: panel-type field in bits 1:0
// a8h: direction, a set bit makes the pin an output
// a9h: input enable in bit 7
// ach: pin state, written data, panel levels on claimed pins, or sampled levels
// adh: dedicated output level in bit 7
// reserved bits read zero and ignore writes
// unmapped offsets read zero and drop writes
//
// pin ownership
// a pin belongs to software unless the panel type claims it
// claimed pins always drive, whatever their direction bit says
// writes to a claimed pin's state bit stay out of the store
// the stored bit comes back once the panel type lets go
//
// timing
// register writes land on the strobe edge
// pin drive follows one edge later through the drive registers
// panel timing inputs reach the pins one edge late as well
// the dedicated output follows its register with no extra edge
// read data stands one cycle after the read strobe, else zero
//
// reset
// every register clears, so all pins start as undriven inputs
// the panel field starts at plain, so no pin is claimed
// input enable starts clear, so input pins read zero
//
// hazards
// a panel type change hands pins over on a single edge
// the board must not drive a claimed pin, or the two fight
// set data before direction, or a newly enabled pin shows
// its old level for a cycle
//
// limitations
// pin count is fixed at seven by the panel signal placement
// input levels are taken as already synchronous to mclk
// reads of a driven pin return the drive level, not the wire
//
// Strobed register access is this design's own decision.
module gpop_port #(
    parameter int PIN_N = gpop_pkg::GPOP_PIN_N
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [gpop_pkg::GPOP_ADDR_W-1:0] reg_addr,
    input wire logic [gpop_pkg::GPOP_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [gpop_pkg::GPOP_DATA_W-1:0] reg_rdata,
    input wire logic [6:0] gpio_in,
    output logic [6:0] gpio_out,
    output logic [6:0] gpio_oe,
    output logic dedicated_output_pin,
    input wire logic panel_drive_signal,
    input wire logic panel_reset_signal,
    input wire logic frame_reset_signal,
    input wire logic start_pulse_signal,
    input wire logic frame_polarity_signal,
    input wire logic panel_reversal_signal,
    input wire logic vertical_shift_clock,
    input wire logic clock_select_signal,
    input wire logic display_inhibit_signal,
    input wire logic panel_power_save_signal
);
    import gpop_pkg::*;

    // pin map is fixed by the panel signal placement
    if (PIN_N != 7) begin : g_bad_pin_n
        $error("gpop_port supports exactly seven gpio pins");
    end

    // the register map assumes a byte-wide address
    if (GPOP_ADDR_W != 8) begin : g_bad_addr_w
        $error("gpop_port needs an eight bit register address");
    end

    // and a byte-wide data path
    if (GPOP_DATA_W != 8) begin : g_bad_data_w
        $error("gpop_port needs an eight bit register data path");
    end

    // input enable must sit inside the data byte
    if (GPOP_INPUT_EN_BIT >= GPOP_DATA_W) begin : g_bad_en_bit
        $error("gpop_port input enable bit lies outside the byte");
    end

    // so must the dedicated output bit
    if (GPOP_GEN_OUT_BIT >= GPOP_DATA_W) begin : g_bad_out_bit
        $error("gpop_port dedicated output bit lies outside the byte");
    end

    // the panel field must fit in the byte
    if (GPOP_PANEL_LSB + GPOP_PANEL_W > GPOP_DATA_W) begin : g_bad_field
        $error("gpop_port panel field lies outside the byte");
    end

    // the two special codes must differ, and reset must claim no pin
    if (GPOP_CODE_FIRST == GPOP_CODE_SECOND || GPOP_RST_PANEL == GPOP_CODE_FIRST
        || GPOP_RST_PANEL == GPOP_CODE_SECOND) begin : g_bad_codes
        $error("gpop_port panel codes clash");
    end

    // a shared offset would make the register decode ambiguous
    if (GPOP_OFS_PANEL_CFG == GPOP_OFS_PIN_DIR || GPOP_OFS_PIN_DIR == GPOP_OFS_INPUT_CFG
        || GPOP_OFS_INPUT_CFG == GPOP_OFS_PIN_STATE || GPOP_OFS_PIN_STATE == GPOP_OFS_GEN_OUT
        || GPOP_OFS_PANEL_CFG == GPOP_OFS_INPUT_CFG || GPOP_OFS_PANEL_CFG == GPOP_OFS_PIN_STATE
        || GPOP_OFS_PANEL_CFG == GPOP_OFS_GEN_OUT || GPOP_OFS_PIN_DIR == GPOP_OFS_PIN_STATE
        || GPOP_OFS_PIN_DIR == GPOP_OFS_GEN_OUT
        || GPOP_OFS_INPUT_CFG == GPOP_OFS_GEN_OUT) begin : g_bad_offsets
        $error("gpop_port register offsets must differ");
    end

    // software-visible state
    logic [6:0] pin_dir_reg;
    logic [6:0] pin_dir_next;
    logic [6:0] pin_data_reg;
    logic [6:0] pin_data_next;
    logic input_en_reg;
    logic input_en_next;
    logic gen_out_reg;
    logic gen_out_next;
    logic [1:0] panel_field_reg;
    logic [1:0] panel_field_next;

    // read port state
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // registered pin drive
    logic [6:0] gpio_out_reg;
    logic [6:0] gpio_out_next;
    logic [6:0] gpio_oe_reg;
    logic [6:0] gpio_oe_next;

    // decoded panel kind and readback helpers
    gpop_panel_t panel_kind;
    logic [6:0] pin_read;
    logic [6:0] pin_in_gated;

    // bundle shared with the pin multiplexer
    gpop_pin_if pins ();

    // panel kind decoded once, shared with the multiplexer
    assign panel_kind = gpop_decode_panel(panel_field_reg);

    // register state and panel levels into the bundle
    assign pins.dir = pin_dir_reg;
    assign pins.data = pin_data_reg;
    assign pins.panel = panel_kind;
    assign pins.sig.panel_drive_signal = panel_drive_signal;
    assign pins.sig.panel_reset_signal = panel_reset_signal;
    assign pins.sig.frame_reset_signal = frame_reset_signal;
    assign pins.sig.start_pulse_signal = start_pulse_signal;
    assign pins.sig.frame_polarity_signal = frame_polarity_signal;
    assign pins.sig.panel_reversal_signal = panel_reversal_signal;
    assign pins.sig.vertical_shift_clock = vertical_shift_clock;
    assign pins.sig.clock_select_signal = clock_select_signal;
    assign pins.sig.display_inhibit_signal = display_inhibit_signal;
    assign pins.sig.panel_power_save_signal = panel_power_save_signal;

    gpop_pin_mux u_pin_mux (
        .pins(pins.mux)
    );

    // register writes; taken pins keep their stored bit
    always_comb begin
        pin_dir_next = pin_dir_reg;
        pin_data_next = pin_data_reg;
        input_en_next = input_en_reg;
        gen_out_next = gen_out_reg;
        panel_field_next = panel_field_reg;
        if (reg_wr) begin
            unique case (reg_addr)
                GPOP_OFS_PIN_DIR: begin
                    pin_dir_next = reg_wdata[6:0];
                end
                GPOP_OFS_INPUT_CFG: begin
                    input_en_next = reg_wdata[GPOP_INPUT_EN_BIT];
                end
                GPOP_OFS_PIN_STATE: begin
                    // a write lands only where software still owns the pin
                    pin_data_next = (pin_data_reg & pins.taken)
                        | (reg_wdata[6:0] & ~pins.taken);
                end
                GPOP_OFS_GEN_OUT: begin
                    gen_out_next = reg_wdata[GPOP_GEN_OUT_BIT];
                end
                GPOP_OFS_PANEL_CFG: begin
                    panel_field_next = reg_wdata[GPOP_PANEL_LSB +: GPOP_PANEL_W];
                end
                default: begin
                    // unmapped writes are dropped
                    pin_dir_next = pin_dir_reg;
                end
            endcase
        end
    end

    // control registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_dir_reg <= GPOP_RST_PINS;
            pin_data_reg <= GPOP_RST_PINS;
            input_en_reg <= 1'b0;
            gen_out_reg <= 1'b0;
            panel_field_reg <= GPOP_RST_PANEL;
        end else begin
            pin_dir_reg <= pin_dir_next;
            pin_data_reg <= pin_data_next;
            input_en_reg <= input_en_next;
            gen_out_reg <= gen_out_next;
            panel_field_reg <= panel_field_next;
        end
    end

    // input function is dead until software enables it
    assign pin_in_gated = input_en_reg ? gpio_in : GPOP_RST_PINS;

    // per-pin readback: driven level for taken and output pins, else the pin
    for (genvar i = 0; i < 7; i++) begin : g_read
        assign pin_read[i] = gpio_oe_reg[i] ? gpio_out_reg[i]
            : pin_in_gated[i];
    end

    // read data is formed from the address and shown one cycle later
    always_comb begin
        rdata_next = GPOP_RST_BYTE;
        if (reg_rd) begin
            unique case (reg_addr)
                GPOP_OFS_PIN_DIR: begin
                    rdata_next[6:0] = pin_dir_reg;
                end
                GPOP_OFS_INPUT_CFG: begin
                    rdata_next[GPOP_INPUT_EN_BIT] = input_en_reg;
                end
                GPOP_OFS_PIN_STATE: begin
                    rdata_next[6:0] = pin_read;
                end
                GPOP_OFS_GEN_OUT: begin
                    rdata_next[GPOP_GEN_OUT_BIT] = gen_out_reg;
                end
                GPOP_OFS_PANEL_CFG: begin
                    rdata_next[GPOP_PANEL_LSB +: GPOP_PANEL_W] = panel_field_reg;
                end
                default: begin
                    // unmapped reads return zero
                    rdata_next = GPOP_RST_BYTE;
                end
            endcase
        end
    end

    // read data holds only in the cycle after the strobe
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_reg <= GPOP_RST_BYTE;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // pin drive from the multiplexer, registered to keep pins glitch free
    always_comb begin
        gpio_out_next = pins.pin_out;
        gpio_oe_next = pins.pin_oe;
    end

    // pin drive registers; all pins are inputs out of reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gpio_out_reg <= GPOP_RST_PINS;
            gpio_oe_reg <= GPOP_RST_PINS;
        end else begin
            gpio_out_reg <= gpio_out_next;
            gpio_oe_reg <= gpio_oe_next;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata = rdata_reg;
    assign gpio_out = gpio_out_reg;
    assign gpio_oe = gpio_oe_reg;
    assign dedicated_output_pin = gen_out_reg;
endmodule : gpop_port

// >>> gpop_port_asserts.sv
// concurrent checks on the ports of the panel override gpio port
module gpop_port_asserts #(
    parameter int PIN_N = 7
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [6:0] gpio_in,
    input wire logic [6:0] gpio_out,
    input wire logic [6:0] gpio_oe,
    input wire logic dedicated_output_pin,
    input wire logic panel_drive_signal,
    input wire logic panel_reset_signal,
    input wire logic frame_reset_signal,
    input wire logic start_pulse_signal,
    input wire logic frame_polarity_signal,
    input wire logic panel_reversal_signal,
    input wire logic vertical_shift_clock,
    input wire logic clock_select_signal,
    input wire logic display_inhibit_signal,
    input wire logic panel_power_save_signal
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pf_reg, pf_next, pfd_reg;
    logic [6:0] dir_reg, dir_next, dird_reg, dat_reg, dat_next, datd_reg, tk, tkd, rexp;
    logic ien_reg, ien_next;
    logic [5:0] psf;
    logic [3:0] pss;
    // taken pins, panel levels in pin order, expected pin-state read
    assign tk = (pf_reg == 2'h3) ? 7'h3F : (pf_reg == 2'h2) ? 7'h0F : 7'h00;
    assign tkd = (pfd_reg == 2'h3) ? 7'h3F : (pfd_reg == 2'h2) ? 7'h0F : 7'h00;
    assign psf = {panel_drive_signal, panel_reset_signal, frame_reset_signal,
        frame_polarity_signal, vertical_shift_clock, display_inhibit_signal};
    assign pss = {start_pulse_signal, panel_reversal_signal, clock_select_signal,
        panel_power_save_signal};
    assign rexp = (gpio_oe & gpio_out) | (~gpio_oe & gpio_in & {7{ien_reg}});
    // shadow of the registers; taken bits keep their stored value
    always_comb begin
        pf_next = pf_reg;
        dir_next = dir_reg;
        dat_next = dat_reg;
        ien_next = ien_reg;
        if (reg_wr && reg_addr == 8'h10) pf_next = reg_wdata[1:0];
        if (reg_wr && reg_addr == 8'hA8) dir_next = reg_wdata[6:0];
        if (reg_wr && reg_addr == 8'hA9) ien_next = reg_wdata[7];
        if (reg_wr && reg_addr == 8'hAC) dat_next = (dat_reg & tk) | (reg_wdata[6:0] & ~tk);
    end
    // the d copies match the extra edge before the pins follow
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {pf_reg, pfd_reg, dir_reg, dird_reg, dat_reg, datd_reg, ien_reg} <= '0;
        end else begin
            {pf_reg, pfd_reg, dir_reg, dird_reg} <= {pf_next, pf_reg, dir_next, dir_reg};
            {dat_reg, datd_reg, ien_reg} <= {dat_next, dat_reg, ien_next};
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    ded_follow_a: assert property (reg_wr && reg_addr == 8'hAD |=>
        dedicated_output_pin == $past(reg_wdata[7])) else $error("gpo pin wrong");
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("rdata not 0");
    rd_unmapped_a: assert property (reg_rd && !(reg_addr inside {8'h10, 8'hA8, 8'hA9,
        8'hAC, 8'hAD}) |=> reg_rdata == 8'h00) else $error("unmapped read not 0");
    ien_read_a: assert property (reg_rd && reg_addr == 8'hA9 |=>
        reg_rdata == {$past(ien_reg), 7'h00}) else $error("input enable read wrong");
    pin_role_a: assert property (gpio_oe == (dird_reg | tkd)) else $error("oe wrong");
    pin_drive_a: assert property ((gpio_out & dird_reg & ~tkd) ==
        (datd_reg & dird_reg & ~tkd)) else $error("gpio drive wrong");
    take_first_a: assert property (pfd_reg == 2'h3 |-> gpio_out[5:0] == $past(psf))
        else $error("first panel pins wrong");
    take_second_a: assert property (pfd_reg == 2'h2 |-> gpio_out[3:0] == $past(pss))
        else $error("second panel pins wrong");
    pin_read_a: assert property (reg_rd && reg_addr == 8'hAC |=>
        reg_rdata == {1'b0, $past(rexp)}) else $error("pin state read wrong");
    dir_read_a: assert property (reg_rd && reg_addr == 8'hA8 |=>
        reg_rdata == {1'b0, $past(dir_reg)}) else $error("direction read wrong");
    panel_read_a: assert property (reg_rd && reg_addr == 8'h10 |=>
        reg_rdata == {6'h00, $past(pf_reg)}) else $error("panel field read wrong");
    gen_read_a: assert property (reg_rd && reg_addr == 8'hAD |=>
        reg_rdata == {$past(dedicated_output_pin), 7'h00}) else $error("gpo read wrong");
    cover property (pfd_reg == 2'h3);
    cover property (pfd_reg == 2'h2);
    cover property (reg_rd && reg_addr == 8'hAC ##1 reg_rdata != 8'h00);
endmodule : gpop_port_asserts

bind gpop_port gpop_port_asserts #(.PIN_N(PIN_N)) u_gpop_port_asserts (.mclk, .rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .gpio_in, .gpio_out, .gpio_oe,
    .dedicated_output_pin, .panel_drive_signal, .panel_reset_signal, .frame_reset_signal,
    .start_pulse_signal, .frame_polarity_signal, .panel_reversal_signal,
    .vertical_shift_clock, .clock_select_signal, .display_inhibit_signal,
    .panel_power_save_signal);

// >>> tb.sv
// self-checking bench for the panel override gpio port
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v, rv;
    logic reg_wr = 1'b0, reg_rd = 1'b0, ded_pin;
    logic [6:0] gpio_in, gpio_out, gpio_oe, ext = 7'h00, dir, d0, tk, ex;
    logic [9:0] psig = 10'h000;
    logic [7:0] addrs [5] = '{8'h10, 8'hA8, 8'hA9, 8'hAC, 8'hAD};
    int n_errors = 0, cmp_count = 0;
    // 40 MHz
    always #12.5 mclk = ~mclk;
    gpop_port #(.PIN_N(7)) u_gpop_port (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .gpio_in, .gpio_out, .gpio_oe, .dedicated_output_pin(ded_pin),
        .display_inhibit_signal(psig[0]), .vertical_shift_clock(psig[1]),
        .frame_polarity_signal(psig[2]), .frame_reset_signal(psig[3]),
        .panel_reset_signal(psig[4]), .panel_drive_signal(psig[5]),
        .panel_power_save_signal(psig[6]), .clock_select_signal(psig[7]),
        .panel_reversal_signal(psig[8]), .start_pulse_signal(psig[9]));
    gpop_board_model u_gpop_board_model (.drv_oe(gpio_oe), .drv_lvl(gpio_out),
        .ext_lvl(ext), .pin_lvl(gpio_in));
    task automatic wr(input logic [7:0] a, input logic [7:0] dt);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= dt;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    // read data is looked at only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] dt);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 dt = reg_rdata;
    endtask : rd
    function automatic logic [6:0] tk_mask(input logic [1:0] c);
        return (c == 2'h3) ? 7'h3F : (c == 2'h2) ? 7'h0F : 7'h00;
    endfunction : tk_mask
    function automatic logic [6:0] panel_lvl(input logic [1:0] c, input logic [9:0] s);
        return (c == 2'h3) ? {1'b0, s[5:0]} : {3'b000, s[9:6]};
    endfunction : panel_lvl
    task automatic report_and_stop();
        $display("TB: checks=%0d errors=%0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // cuts a hang short
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        report_and_stop();
    end
    // main sequence
    initial begin
        void'($urandom(44));
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(addrs[i], v);
            `CHK(v, 8'h00)
        end
        wr(8'h55, 8'hFF);
        rd(8'h55, v);
        `CHK(v, 8'h00)
        $display("TB: reset and unmapped test done");
        @(posedge mclk);
        ext <= 7'h5A;
        rd(8'hAC, v);
        `CHK(v, 8'h00)
        wr(8'hA9, 8'hFF);
        rd(8'hA9, v);
        `CHK(v, 8'h80)
        for (int i = 0; i < 8; i++) begin
            dir = (i == 0) ? 7'h7F : (i == 1) ? 7'h00 : 7'($urandom);
            d0 = 7'($urandom);
            @(posedge mclk);
            ext <= 7'($urandom);
            wr(8'hA8, {1'b0, dir});
            wr(8'hAC, {1'b0, d0});
            repeat (2) @(posedge mclk);
            #1 `CHK(gpio_oe, dir)
            `CHK(gpio_out & dir, d0 & dir)
            rd(8'hAC, v);
            `CHK(v, {1'b0, (d0 & dir) | (ext & ~dir)})
            rd(8'hA8, rv);
            `CHK(rv, {1'b0, dir})
        end
        $display("TB: plain gpio test done");
        for (int i = 0; i < 6; i++) begin
            v = (i % 2) ? 8'h00 : 8'(8'h80 | $urandom);
            wr(8'hAD, v);
            #1 `CHK(ded_pin, v[7])
            rd(8'hAD, rv);
            `CHK(rv, {v[7], 7'h00})
        end
        $display("TB: dedicated output test done");
        wr(8'hA8, 8'h7F);
        for (int c = 0; c < 4; c++) begin
            d0 = 7'($urandom);
            tk = tk_mask(2'(c));
            wr(8'h10, 8'h00);
            wr(8'hAC, {1'b0, d0});
            wr(8'h10, 8'(c));
            psig <= 10'($urandom);
            rd(8'h10, rv);
            `CHK(rv, 8'(c))
            wr(8'hAC, {1'b0, ~d0});
            repeat (4) begin
                @(posedge mclk);
                psig <= 10'($urandom);
            end
            repeat (2) @(posedge mclk);
            ex = (panel_lvl(2'(c), psig) & tk) | (~d0 & ~tk);
            #1 `CHK(gpio_out, ex)
            `CHK(gpio_oe, 7'h7F)
            rd(8'hAC, v);
            `CHK(v, {1'b0, ex})
            wr(8'h10, 8'h00);
            repeat (3) @(posedge mclk);
            #1 `CHK(gpio_out, (d0 & tk) | (~d0 & ~tk))
        end
        $display("TB: panel takeover test done");
        report_and_stop();
    end
endmodule : tb
